// [hdl/swcd_decoder.sv]
// Secondary configuration word decoder: serial capture, decode and config registers
//
// Overview of operation
// - Command 00 loads transmit A divider from 13..9, receive A from 6..2.
// - Command 01 loads six-bit signed A trims from 14..9 and 7..2.
// - Command 10 loads six-bit B dividers from 14..9 and 7..2.
// - Command 11 writes control: bit2 high-pass, bit3 loopback, bit4 auxiliary inputs.
// - Control bit 5 picks asynchronous (0) or synchronous (1) sections.
// - Control bits 7..6 are held and driven to the gain stage.
// - Control bit 9 inserts the sin(x)/x correction filter.
// - Control bits 10 and 11 drive two general-purpose output pins.
// - Control bits 8 and 12..15 are ignored.
// - Words arrive MSB first; in byte mode the second byte starts at bit 7.
// - Reset initialises every configuration register including control.
// - Reset sets all four dividers to 0x12 and both trims to 0x01.
// - Reset clears control bits 11,10,4,3 and sets 9,7,6,5,2.
// - Reset dividers give 16 kHz conversion at 10.368 MHz master clock.
// - In synchronous mode receive timing follows the transmit settings only.
// - Secondary word only follows a primary word ending in 11.
module swcd_decoder
  import swcd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic shift_clock_i,
  input wire logic transmit_frame_sync_i,
  input wire logic host_to_device_serial_i,
  input wire logic word_mode_i,
  output logic [4:0] transmit_a_divider_o,
  output logic [4:0] receive_a_divider_o,
  output logic [5:0] transmit_a_trim_o,
  output logic [5:0] receive_a_trim_o,
  output logic [5:0] transmit_b_divider_o,
  output logic [5:0] receive_b_divider_o,
  output logic [4:0] timing_rx_a_divider_o,
  output logic [5:0] timing_rx_a_trim_o,
  output logic [5:0] timing_rx_b_divider_o,
  output logic [15:0] control_word_o,
  output logic hpf_en_o,
  output logic loopback_en_o,
  output logic aux_en_o,
  output logic sync_mode_o,
  output logic [1:0] gain_sel_o,
  output logic sinx_en_o,
  output logic general_output_ten_o,
  output logic general_output_eleven_o,
  output logic secondary_pending_o,
  output logic config_load_o
);
  import swcd_pkg::*;

  logic sclk_fall;
  logic fsx_level;
  logic fsx_fall;
  logic dx_level;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] word_q;
  logic word_done_q;
  logic first_bit_q;
  swcd_state_e state_q;
  logic [4:0] txa_div_q;
  logic [4:0] rxa_div_q;
  logic [5:0] txa_trim_q;
  logic [5:0] rxa_trim_q;
  logic [5:0] txb_div_q;
  logic [5:0] rxb_div_q;
  logic [15:0] ctl_q;
  logic [4:0] eff_rxa_div_q;
  logic [5:0] eff_rxa_trim_q;
  logic [5:0] eff_rxb_div_q;
  logic [1:0] cmd;
  logic bit_take;

  // Shift clock and frame sync idle high, so they reset high: no false edge
  swcd_pin_sync u_sync_sclk (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .pin_i(shift_clock_i),
    .rst_level_i(1'b1),
    .level_o(),
    .rise_o(),
    .fall_o(sclk_fall)
  );

  swcd_pin_sync u_sync_fsx (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .pin_i(transmit_frame_sync_i),
    .rst_level_i(1'b1),
    .level_o(fsx_level),
    .rise_o(),
    .fall_o(fsx_fall)
  );

  swcd_pin_sync u_sync_dx (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .pin_i(host_to_device_serial_i),
    .rst_level_i(1'b0),
    .level_o(dx_level),
    .rise_o(),
    .fall_o()
  );

  // Bits are taken on the falling shift edge while the frame is open
  assign bit_take = sclk_fall && !fsx_level;
  assign cmd = word_q[CMD_MSB:CMD_LSB];

  // Bit counter; byte mode keeps the count across the two byte frames
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bit_cnt_q <= 5'h0_000;
    end else if (bit_take) begin
      bit_cnt_q <= (bit_cnt_q == BIT_CNT_LAST) ? 5'h0_000 : bit_cnt_q + 5'h0_001;
    end else if (fsx_fall && (word_mode_i || bit_cnt_q != BIT_CNT_BYTE)) begin
      bit_cnt_q <= 5'h0_000;
    end
  end

  // MSB first: earlier bits walk toward bit 15
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shift_q <= 16'h0000;
    end else if (bit_take) begin
      shift_q <= {shift_q[14:0], dx_level};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      first_bit_q <= 1'b0;
    end else if (bit_take && bit_cnt_q == 5'h0_000) begin
      first_bit_q <= dx_level;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      word_q <= 16'h0000;
      word_done_q <= 1'b0;
    end else begin
      word_done_q <= bit_take && (bit_cnt_q == BIT_CNT_LAST);
      if (bit_take && bit_cnt_q == BIT_CNT_LAST) begin
        word_q <= {shift_q[14:0], dx_level};
      end
    end
  end

  // Primary/secondary sequencing; a primary ending in 11 arms the next word
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= SWCD_WAIT_PRIMARY;
    end else begin
      unique case (state_q)
        SWCD_WAIT_PRIMARY: begin
          if (word_done_q && cmd == CMD_SECONDARY_REQ) begin
            state_q <= SWCD_WAIT_SECONDARY;
          end
        end
        SWCD_WAIT_SECONDARY: begin
          if (word_done_q) begin
            state_q <= SWCD_LOAD;
          end
        end
        SWCD_LOAD: begin
          state_q <= SWCD_WAIT_PRIMARY;
        end
      endcase
    end
  end

  assign config_load_o = (state_q == SWCD_LOAD);
  assign secondary_pending_o = (state_q == SWCD_WAIT_SECONDARY);

  // A dividers and trims
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      txa_div_q <= DIV_A_RST;
      rxa_div_q <= DIV_A_RST;
      txa_trim_q <= TRIM_A_RST;
      rxa_trim_q <= TRIM_A_RST;
    end else if (config_load_o && cmd == CMD_DIV_A) begin
      txa_div_q <= word_q[TXA_DIV_MSB:TXA_DIV_LSB];
      rxa_div_q <= word_q[RXA_DIV_MSB:RXA_DIV_LSB];
    end else if (config_load_o && cmd == CMD_TRIM_A) begin
      txa_trim_q <= word_q[TX_WIDE_MSB:TX_WIDE_LSB];
      rxa_trim_q <= word_q[RX_WIDE_MSB:RX_WIDE_LSB];
    end
  end

  // B dividers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      txb_div_q <= DIV_B_RST;
      rxb_div_q <= DIV_B_RST;
    end else if (config_load_o && cmd == CMD_DIV_B) begin
      txb_div_q <= word_q[TX_WIDE_MSB:TX_WIDE_LSB];
      rxb_div_q <= word_q[RX_WIDE_MSB:RX_WIDE_LSB];
    end
  end

  // Control register; unassigned bits are masked so they always read zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctl_q <= CTL_RST;
    end else if (config_load_o && cmd == CMD_CONTROL) begin
      ctl_q <= word_q & CTL_KEEP_MASK;
    end
  end

  // Receive timing set; limits are not checked here, the host owns them
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      eff_rxa_div_q <= DIV_A_RST;
      eff_rxa_trim_q <= TRIM_A_RST;
      eff_rxb_div_q <= DIV_B_RST;
    end else if (ctl_q[CTL_SYNC]) begin
      eff_rxa_div_q <= txa_div_q;
      eff_rxa_trim_q <= txa_trim_q;
      eff_rxb_div_q <= txb_div_q;
    end else begin
      eff_rxa_div_q <= rxa_div_q;
      eff_rxa_trim_q <= rxa_trim_q;
      eff_rxb_div_q <= rxb_div_q;
    end
  end

  assign transmit_a_divider_o = txa_div_q;
  assign receive_a_divider_o = rxa_div_q;
  assign transmit_a_trim_o = txa_trim_q;
  assign receive_a_trim_o = rxa_trim_q;
  assign transmit_b_divider_o = txb_div_q;
  assign receive_b_divider_o = rxb_div_q;
  assign timing_rx_a_divider_o = eff_rxa_div_q;
  assign timing_rx_a_trim_o = eff_rxa_trim_q;
  assign timing_rx_b_divider_o = eff_rxb_div_q;
  assign control_word_o = ctl_q;
  assign hpf_en_o = ctl_q[CTL_HPF];
  assign loopback_en_o = ctl_q[CTL_LOOPBACK];
  assign aux_en_o = ctl_q[CTL_AUX];
  assign sync_mode_o = ctl_q[CTL_SYNC];
  assign gain_sel_o = ctl_q[CTL_GAIN_MSB:CTL_GAIN_LSB];
  assign sinx_en_o = ctl_q[CTL_SINX];
  assign general_output_ten_o = ctl_q[CTL_GPO_TEN];
  assign general_output_eleven_o = ctl_q[CTL_GPO_ELEVEN];

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  a_div_a_load: assert property (config_load_o && cmd == CMD_DIV_A |=>
      transmit_a_divider_o == $past(word_q[13:9]) && receive_a_divider_o == $past(word_q[6:2]))
    else $error("A dividers not loaded from secondary word");

  a_trim_a_load: assert property (config_load_o && cmd == CMD_TRIM_A |=>
      transmit_a_trim_o == $past(word_q[14:9]) && receive_a_trim_o == $past(word_q[7:2]))
    else $error("A trims not loaded from secondary word");

  a_div_b_load: assert property (config_load_o && cmd == CMD_DIV_B |=>
      transmit_b_divider_o == $past(word_q[14:9]) && receive_b_divider_o == $past(word_q[7:2])
      && transmit_a_divider_o == $past(transmit_a_divider_o))
    else $error("B dividers not loaded or A divider disturbed");

  a_ctl_bits_write: assert property (config_load_o && cmd == CMD_CONTROL |=>
      {aux_en_o, loopback_en_o, hpf_en_o} == $past(word_q[4:2]))
    else $error("Control filter/loopback/aux bits wrong");

  a_sync_mode_follow: assert property (sync_mode_o |=>
      timing_rx_b_divider_o == $past(transmit_b_divider_o))
    else $error("Synchronous receive timing not following transmit");

  a_gain_sinx_bits: assert property (config_load_o && cmd == CMD_CONTROL |=>
      gain_sel_o == $past(word_q[7:6]) && sinx_en_o == $past(word_q[9]))
    else $error("Gain or correction filter bit not taken");

  a_sinx_hold: assert property (!(config_load_o && cmd == CMD_CONTROL) |=>
      $stable(sinx_en_o))
    else $error("Correction filter bit changed without control write");

  a_gpo_drive: assert property (config_load_o && cmd == CMD_CONTROL |=>
      general_output_ten_o == $past(word_q[10]) && general_output_eleven_o == $past(word_q[11]))
    else $error("General outputs not driven from control word");

  a_ctl_unused_zero: assert property ((control_word_o & ~CTL_KEEP_MASK) == 16'h0000)
    else $error("Unassigned control bits held");

  a_msb_first: assert property (word_done_q |-> word_q[15] == first_bit_q)
    else $error("First shifted bit not in bit 15");

  a_reset_values: assert property (disable iff (1'b0) $past(srst_i) |->
      transmit_a_divider_o == 5'h12 && receive_b_divider_o == 6'h12
      && receive_a_divider_o == 5'h12 && transmit_b_divider_o == 6'h12
      && transmit_a_trim_o == 6'h01 && receive_a_trim_o == 6'h01)
    else $error("Divider or trim reset value wrong");

  a_reset_control: assert property (disable iff (1'b0) $past(srst_i) |->
      control_word_o == 16'h02E4)
    else $error("Control reset value wrong");

  a_sync_uses_tx: assert property (sync_mode_o && $stable(transmit_a_divider_o)
      && $stable(transmit_a_trim_o) |=> timing_rx_a_divider_o == $past(transmit_a_divider_o)
      && timing_rx_a_trim_o == $past(transmit_a_trim_o))
    else $error("Synchronous receive A timing not from transmit");

  a_secondary_gate: assert property (word_done_q && state_q == SWCD_WAIT_PRIMARY
      |=> !config_load_o ##1 !config_load_o)
    else $error("Configuration loaded without primary request");

  c_div_a_word: cover property (config_load_o && cmd == CMD_DIV_A);
  c_trim_word: cover property (config_load_o && cmd == CMD_TRIM_A);
  c_control_word: cover property (config_load_o && cmd == CMD_CONTROL);
  c_byte_mode_word: cover property (!word_mode_i && config_load_o);

endmodule : swcd_decoder

// [hdl/swcd_pkg.sv]
// Package: field layout, reset values and encodings of the secondary word decoder
package swcd_pkg;

  // Serial word shape
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] BIT_CNT_LAST = 5'h0_00F;
  localparam logic [4:0] BIT_CNT_BYTE = 5'h0_008;

  // Command field in the two lowest bits
  localparam int CMD_LSB = 0;
  localparam int CMD_MSB = 1;
  localparam logic [1:0] CMD_DIV_A = 2'h0;
  localparam logic [1:0] CMD_TRIM_A = 2'h1;
  localparam logic [1:0] CMD_DIV_B = 2'h2;
  localparam logic [1:0] CMD_CONTROL = 2'h3;
  localparam logic [1:0] CMD_SECONDARY_REQ = 2'h3;

  // Payload fields
  localparam int TXA_DIV_MSB = 13;
  localparam int TXA_DIV_LSB = 9;
  localparam int RXA_DIV_MSB = 6;
  localparam int RXA_DIV_LSB = 2;
  localparam int TX_WIDE_MSB = 14;
  localparam int TX_WIDE_LSB = 9;
  localparam int RX_WIDE_MSB = 7;
  localparam int RX_WIDE_LSB = 2;

  // Control word bit positions
  localparam int CTL_HPF = 2;
  localparam int CTL_LOOPBACK = 3;
  localparam int CTL_AUX = 4;
  localparam int CTL_SYNC = 5;
  localparam int CTL_GAIN_LSB = 6;
  localparam int CTL_GAIN_MSB = 7;
  localparam int CTL_SINX = 9;
  localparam int CTL_GPO_TEN = 10;
  localparam int CTL_GPO_ELEVEN = 11;
  // Assigned control bits; 0, 1, 8 and 12..15 are dropped
  localparam logic [15:0] CTL_KEEP_MASK = 16'h0EFC;

  // Reset values
  localparam logic [4:0] DIV_A_RST = 5'h12;
  localparam logic [5:0] DIV_B_RST = 6'h12;
  localparam logic [5:0] TRIM_A_RST = 6'h01;
  localparam logic [15:0] CTL_RST = 16'h02E4;

  // Reference figures the reset dividers are sized for
  localparam int REF_MCLK_HZ = 10_368_000;
  localparam int REF_CONV_HZ = 16_000;

  typedef enum logic [2:0] {
    SWCD_WAIT_PRIMARY = 3'b001,
    SWCD_WAIT_SECONDARY = 3'b010,
    SWCD_LOAD = 3'b100
  } swcd_state_e;

endpackage : swcd_pkg

// [hdl/swcd_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
module swcd_pin_sync (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  input wire logic rst_level_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge mclk_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Only the agreed value of stages two and three counts as a change
  // Reset to the pin's idle level so that release brings no false edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      level_q <= rst_level_i;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_o = level_q;
  assign rise_o = !srst_i && (s2_q == s3_q) && s3_q && !level_q;
  assign fall_o = !srst_i && (s2_q == s3_q) && !s3_q && level_q;

endmodule : swcd_pin_sync

// [tb/swcd_host_model.sv]
// Host serial port model: shifts one 16-bit word out, MSB first
module swcd_host_model (
  input wire logic mclk_i,
  input wire logic start_i,
  input wire logic byte_mode_i,
  input wire logic [15:0] word_i,
  input wire logic [3:0] half_i,
  output logic shift_clock_o,
  output logic frame_sync_n_o,
  output logic serial_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  task automatic wait_mclk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_mclk

  // Shift clock parks high between frames
  initial begin
    shift_clock_o = 1'b1;
    frame_sync_n_o = 1'b1;
    serial_o = 1'b0;
    done_o = 1'b0;
  end

  always begin
    @(posedge mclk_i);
    if (start_i) begin
      for (int b = 15; b >= 0; b--) begin
        if (b == 15 || (byte_mode_i && b == 7)) begin
          frame_sync_n_o <= 1'b0;
        end
        serial_o <= word_i[b];
        wait_mclk(half_i);
        shift_clock_o <= 1'b0;
        wait_mclk(half_i);
        shift_clock_o <= 1'b1;
        if (b == 0 || (byte_mode_i && b == 8)) begin
          wait_mclk(1);
          frame_sync_n_o <= 1'b1;
          // Released line must not keep showing the last bit
          serial_o <= ~word_i[b];
          wait_mclk(8 * half_i);
        end
      end
      done_o <= 1'b1;
      wait_mclk(1);
      done_o <= 1'b0;
    end
  end
endmodule : swcd_host_model

// [tb/test_swcd_decoder.sv]
// Self-checking bench for the secondary word decoder
module test_swcd_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic word_mode_i = 1'b1;
  logic start = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [3:0] half = 4'h4;
  logic sclk, fs_n, sdat, done, hpf, lpb, aux, syn, sinx, g10, g11, pend, load;
  logic [4:0] ta, ra, tra;
  logic [5:0] tt, rt, tb, rb, trt, trb;
  logic [15:0] ctl;
  logic [1:0] gain;
  logic [4:0] e_ta, e_ra;
  logic [5:0] e_tt, e_rt, e_tb, e_rb;
  logic [15:0] e_ctl;
  int seed = 32'h6f81;
  int error_cnt = 0;
  int cmp_count = 0;
  int load_cnt = 0;
  int exp_loads = 0;

  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (load === 1'b1) load_cnt <= load_cnt + 1;

  swcd_decoder swcd_decoder_i (.mclk_i(mclk_i), .srst_i(srst_i), .shift_clock_i(sclk),
    .transmit_frame_sync_i(fs_n), .host_to_device_serial_i(sdat), .word_mode_i(word_mode_i),
    .transmit_a_divider_o(ta), .receive_a_divider_o(ra), .transmit_a_trim_o(tt),
    .receive_a_trim_o(rt), .transmit_b_divider_o(tb), .receive_b_divider_o(rb),
    .timing_rx_a_divider_o(tra), .timing_rx_a_trim_o(trt), .timing_rx_b_divider_o(trb),
    .control_word_o(ctl), .hpf_en_o(hpf), .loopback_en_o(lpb), .aux_en_o(aux),
    .sync_mode_o(syn), .gain_sel_o(gain), .sinx_en_o(sinx), .general_output_ten_o(g10),
    .general_output_eleven_o(g11), .secondary_pending_o(pend), .config_load_o(load));

  swcd_host_model swcd_host_model_i (.mclk_i(mclk_i), .start_i(start),
    .byte_mode_i(~word_mode_i), .word_i(word), .half_i(half), .shift_clock_o(sclk),
    .frame_sync_n_o(fs_n), .serial_o(sdat), .done_o(done));

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic int rnd(input int lo, input int span);
    return lo + int'($unsigned($random(seed)) % span);
  endfunction : rnd

  // Field values kept inside the host's programming limits
  function automatic logic [15:0] gen(input logic [1:0] c, input logic [15:0] r);
    case (c)
      2'b00: return {r[15:14], 5'(rnd(5, 27)), r[8:7], 5'(rnd(5, 27)), 2'b00};
      2'b01: return {r[15], 6'(rnd(61, 7)), r[8], 6'(rnd(61, 7)), 2'b01};
      2'b10: return {r[15], 6'(rnd(15, 49)), r[8], 6'(rnd(15, 49)), 2'b10};
      default: return {r[15:2], 2'b11};
    endcase
  endfunction : gen

  task automatic expect_word(input logic [15:0] w);
    case (w[1:0])
      2'b00: begin e_ta = w[13:9]; e_ra = w[6:2]; end
      2'b01: begin e_tt = w[14:9]; e_rt = w[7:2]; end
      2'b10: begin e_tb = w[14:9]; e_rb = w[7:2]; end
      default: e_ctl = w & 16'h0EFC;
    endcase
  endtask : expect_word

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    e_ta = 5'h12; e_ra = 5'h12; e_tb = 6'h12; e_rb = 6'h12;
    e_tt = 6'h01; e_rt = 6'h01;
    e_ctl = 16'h02E4;
    repeat (2) @(posedge mclk_i);
  endtask : do_reset

  task automatic send(input logic [15:0] w);
    int n;
    word <= w;
    half <= 4'(rnd(4, 4));
    word_mode_i <= 1'($random(seed));
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge mclk_i);
    if (n == 2000) begin
      error_cnt++;
      $display("[ERR] t=%0t done got=%h exp=%h", $time, done, 1'b1);
      results();
    end
    repeat (6) @(posedge mclk_i);
  endtask : send

  task automatic check_all();
    logic s;
    s = e_ctl[5];
    chk(16'(ta), 16'(e_ta));
    chk(16'(ra), 16'(e_ra));
    chk(16'(tt), 16'(e_tt));
    chk(16'(rt), 16'(e_rt));
    chk(16'(tb), 16'(e_tb));
    chk(16'(rb), 16'(e_rb));
    chk(ctl, e_ctl);
    chk(16'({hpf, lpb, aux}), 16'({e_ctl[2], e_ctl[3], e_ctl[4]}));
    chk(16'(syn), 16'(s));
    chk(16'(gain), 16'(e_ctl[7:6]));
    chk(16'(sinx), 16'(e_ctl[9]));
    chk(16'({g10, g11}), 16'({e_ctl[10], e_ctl[11]}));
    chk(16'(tra), 16'(s ? e_ta : e_ra));
    chk(16'(trt), 16'(s ? e_tt : e_rt));
    chk(16'(trb), 16'(s ? e_tb : e_rb));
    chk(16'(pend), 16'h0000);
  endtask : check_all

  task automatic secondary(input logic [15:0] w);
    send(gen(2'b11, 16'($random(seed))));
    chk(16'(pend), 16'h0001);
    send(w);
    expect_word(w);
    exp_loads++;
    check_all();
  endtask : secondary

  initial begin
    do_reset();
    check_all();
    secondary(16'hFFFF);
    secondary(16'h0003);
    // Unarmed word must be taken as primary and change nothing
    send(16'hFE00);
    check_all();
    for (int i = 0; i < 24; i++) secondary(gen(2'(i), 16'($random(seed))));
    do_reset();
    check_all();
    secondary(gen(2'b00, 16'($random(seed))));
    chk(16'(load_cnt), 16'(exp_loads));
    results();
  end
endmodule : test_swcd_decoder
